// >>> design/eewp_params.svh
`ifndef EEWP_PARAMS_SVH
`define EEWP_PARAMS_SVH

// Select byte layout
`define EEWP_SEL_TYPE_HI   7
`define EEWP_SEL_TYPE_LO   4
`define EEWP_SEL_CS_BIT    3
`define EEWP_SEL_BLK_HI    2
`define EEWP_SEL_BLK_LO    1
`define EEWP_SEL_RW_BIT    0
`define EEWP_RW_READ       1'h1

// Bits per byte on the wire, ack follows the last one
`define EEWP_BYTE_BITS     4'h8

// Array geometry
`define EEWP_TOP_BLOCK     2'h3
`define EEWP_ROW_HI        7
`define EEWP_ROW_LO        3
`define EEWP_PAGE_LO_BITS  4

// Protect boundary pointer at the top location
`define EEWP_PTR_ADDR      10'h3ff
`define EEWP_PTR_RESET     8'hff
`define EEWP_PTR_BND_HI    7
`define EEWP_PTR_BND_LO    4
`define EEWP_PTR_ARM_BIT   2

// Self-timed program cycle
`define EEWP_TW_MS         10
`define EEWP_TW_SPAN_MULT  2
`define EEWP_CLK_KHZ       250000

// Buffering between the bus and the array latches
`define EEWP_FIFO_DEPTH    4

`endif

// >>> design/eewp_pkg.sv
package eewp_pkg;

	// Protocol phase of the bus front end
	typedef enum logic [2:0] {
		EEWP_IDLE,
		EEWP_DEVSEL,
		EEWP_ACK_DEV,
		EEWP_ADDR,
		EEWP_ACK_ADDR,
		EEWP_DATA,
		EEWP_ACK_DATA
	} eewp_phase_t;

	// Whole state of the front end
	typedef struct packed {
		logic [2:0]  scl_sync;   // Two-flop synchroniser plus history
		logic [2:0]  sda_sync;
		logic [3:0]  pin_meta;   // First stage of the static pins
		logic [3:0]  pin_sync;   // {pe, wc, mode, cs}
		eewp_phase_t phase;
		logic [3:0]  bit_cnt;
		logic [7:0]  shift;
		logic        rd_dir;
		logic        page_mode;
		logic [1:0]  block;
		logic [7:0]  addr;
		logic [4:0]  first_row;
		logic        span;
		logic        got_data;
		logic        sda_oe;
		logic        push_v;
		logic [17:0] push_word;
		logic        busy;
		logic [23:0] timer;
		logic        prog_start;
		logic [7:0]  ptr;        // Shadow of the boundary byte
		logic        ptr_pend;
		logic [7:0]  ptr_new;
	} eewp_state_t;

endpackage

// >>> design/eewp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module eewp_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	// Fill side
	input  wire logic             i_valid,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_ready,
	// Drain side
	output logic                  o_valid,
	output logic [WIDTH-1:0]      o_data,
	input  wire logic             i_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];   // Storage words
	logic [AW-1:0]    wr_ptr;        // Next slot to fill
	logic [AW-1:0]    rd_ptr;        // Oldest slot
	logic [AW:0]      count;         // Words held
	logic             push;
	logic             pop;

	// Honest flags straight from the count
	assign o_ready = (count != (AW+1)'(DEPTH));
	assign o_valid = (count != '0);
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	// Pointers wrap at DEPTH so depths that are not powers of two work
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= i_data;
				wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Head word shown from storage through a mux at rd_ptr; no flop of its own, mem is registered
	assign o_data = mem[rd_ptr];

endmodule

`default_nettype wire

// >>> design/eewp_top.sv
// How it works
// - Top four select bits must match type code
// - Fifth select bit must equal chip-select pin
// - Sixth and seventh bits pick 256-byte block
// - Last select bit: one reads, zero writes
// - Matching select byte acknowledged on ninth bit
// - Mode pin high multibyte, low page write
// - Write select followed by acknowledged byte address
// - Write inhibit high leaves array unchanged
// - Byte write is one byte then stop
// - Multibyte: one to eight acknowledged bytes (code sets no byte limit; it acks each byte while the latch queue has room)
// - Multibyte program time doubles when row bits differ
// - Page write takes up to sixteen bytes
// - Page mode increments only low four bits
// - Stop starts program cycle; ignore bus meanwhile
// - No acknowledge while busy; acknowledge when done
// - Armed enable pin blocks boundary up to top
// - Boundary byte upper nibble, sixteen-byte steps
// - Protection confined to the top block
// - Enable pin low: top byte is ordinary
// - Start, then eight select bits MSB first
// - Data sampled on clock rising edge
`timescale 1ns/1ps
`default_nettype none

`include "eewp_params.svh"

module eewp_top
	import eewp_pkg::*;
#(
	parameter logic [3:0] TYPE_ID       = 4'h5,  // Arbitrary identifier value
	parameter bit         HW_WRITE_CTRL = 1'b0,  // Write-inhibit variant when set
	parameter int         TW_CYCLES     = `EEWP_TW_MS * `EEWP_CLK_KHZ,
	parameter int         FIFO_DEPTH    = `EEWP_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	// Two-wire link
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	// Static pins
	input  wire logic       i_chip_select_pin,
	input  wire logic       i_mode_pin,
	input  wire logic       i_write_inhibit_pin,
	input  wire logic       i_protect_enable_pin,
	// Latch port toward the array
	output logic            o_wr_valid,
	output logic [9:0]      o_wr_addr,
	output logic [7:0]      o_wr_data,
	input  wire logic       i_wr_ready,
	// Program cycle status
	output logic            o_prog_start,
	output logic            o_busy,
	output logic [7:0]      o_protect_boundary_pointer
);

	localparam logic [23:0] TW_CNT      = 24'(TW_CYCLES - 1);
	localparam logic [23:0] TW_SPAN_CNT = 24'(TW_CYCLES * `EEWP_TW_SPAN_MULT - 1);

	eewp_state_t st;         // Registered state
	eewp_state_t next_st;    // Next state
	logic        fifo_ready; // Room for one more latched byte
	logic [17:0] fifo_word;  // {array address, data}

	// Protection test for one array address
	function automatic logic is_protected(
		input logic [9:0] a,
		input logic [7:0] ptr,
		input logic       pe
	);
		logic [9:0] bnd;
		bnd = {`EEWP_TOP_BLOCK, ptr[`EEWP_PTR_BND_HI:`EEWP_PTR_BND_LO], 4'h0};
		is_protected = pe & ~ptr[`EEWP_PTR_ARM_BIT] & (a >= bnd);
	endfunction

	// Next byte address within the block
	function automatic logic [7:0] next_addr(
		input logic [7:0] a,
		input logic       page
	);
		logic [3:0] low;
		low = a[`EEWP_PAGE_LO_BITS-1:0] + 4'h1;
		if (page) begin
			next_addr = {a[7:`EEWP_PAGE_LO_BITS], low};
		end else begin
			next_addr = a + 8'h01;
		end
	endfunction

	// Protocol engine, all state in one struct
	always_comb begin
		logic       s_scl;
		logic       d_scl;
		logic       s_sda;
		logic       d_sda;
		logic       rise;
		logic       fall;
		logic       start_c;
		logic       stop_c;
		logic [9:0] full_addr;
		logic       blocked;
		logic       sel_ok;
		s_scl     = st.scl_sync[1];
		d_scl     = st.scl_sync[2];
		s_sda     = st.sda_sync[1];
		d_sda     = st.sda_sync[2];
		rise      = s_scl & ~d_scl;
		fall      = ~s_scl & d_scl;
		start_c   = s_scl & d_scl & d_sda & ~s_sda;
		stop_c    = s_scl & d_scl & ~d_sda & s_sda;
		full_addr = {st.block, st.addr};
		blocked   = is_protected(full_addr, st.ptr, st.pin_sync[3])
			| (HW_WRITE_CTRL & st.pin_sync[2]);
		sel_ok    = (st.shift[`EEWP_SEL_TYPE_HI:`EEWP_SEL_TYPE_LO] == TYPE_ID)
			& (st.shift[`EEWP_SEL_CS_BIT] == st.pin_sync[0])
			& ~st.busy;

		next_st            = st;
		next_st.push_v     = 1'b0;
		next_st.prog_start = 1'b0;

		// Synchronisers: logic reads the second stage and the history flop behind it
		next_st.scl_sync = {st.scl_sync[1:0], i_scl};
		next_st.sda_sync = {st.sda_sync[1:0], i_sda};
		next_st.pin_meta = {i_protect_enable_pin, i_write_inhibit_pin, i_mode_pin,
			i_chip_select_pin};
		next_st.pin_sync = st.pin_meta;

		// Program cycle timer
		if (st.busy) begin
			if (st.timer == '0) begin
				next_st.busy = 1'b0;
			end else begin
				next_st.timer = st.timer - 24'h1;
			end
		end

		if (st.busy) begin
			// Bus is ignored entirely until programming ends
			next_st.phase  = EEWP_IDLE;
			next_st.sda_oe = 1'b0;
		end else if (stop_c) begin
			// Stop after at least one data byte starts programming
			if (st.got_data && !st.rd_dir) begin
				next_st.busy       = 1'b1;
				next_st.prog_start = 1'b1;
				next_st.timer      = (st.span && !st.page_mode) ? TW_SPAN_CNT : TW_CNT;
				if (st.ptr_pend) begin
					next_st.ptr = st.ptr_new;
				end
			end
			next_st.ptr_pend = 1'b0;
			next_st.got_data = 1'b0;
			next_st.phase    = EEWP_IDLE;
			next_st.sda_oe   = 1'b0;
		end else if (start_c) begin
			// Start or repeated start opens a new select byte
			next_st.phase    = EEWP_DEVSEL;
			next_st.bit_cnt  = '0;
			next_st.sda_oe   = 1'b0;
			next_st.got_data = 1'b0;
			next_st.ptr_pend = 1'b0;
		end else begin
			case (st.phase)
				EEWP_DEVSEL, EEWP_ADDR, EEWP_DATA: begin
					if (rise) begin
						// Sample on the rising clock, MSB first
						next_st.shift   = {st.shift[6:0], s_sda};
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end else if (fall && st.bit_cnt == `EEWP_BYTE_BITS) begin
						if (st.phase == EEWP_DEVSEL) begin
							if (sel_ok) begin
								next_st.block = st.shift[`EEWP_SEL_BLK_HI:`EEWP_SEL_BLK_LO];
								next_st.rd_dir = (st.shift[`EEWP_SEL_RW_BIT] == `EEWP_RW_READ);
								// Write-control variant has no mode pin, it pages
								next_st.page_mode = HW_WRITE_CTRL | ~st.pin_sync[1];
								next_st.sda_oe = 1'b1;
								next_st.phase  = EEWP_ACK_DEV;
							end else begin
								// Silent: no ack, wait for next start
								next_st.phase = EEWP_IDLE;
							end
						end else if (st.phase == EEWP_ADDR) begin
							next_st.addr      = st.shift;
							next_st.first_row = st.shift[`EEWP_ROW_HI:`EEWP_ROW_LO];
							next_st.span      = 1'b0;
							next_st.sda_oe    = 1'b1;
							next_st.phase     = EEWP_ACK_ADDR;
						end else if (fifo_ready) begin
							// Data byte: ack always, latch only if writable
							next_st.got_data = 1'b1;
							next_st.span = st.span
								| (st.addr[`EEWP_ROW_HI:`EEWP_ROW_LO] != st.first_row);
							if (!blocked) begin
								next_st.push_v    = 1'b1;
								next_st.push_word = {full_addr, st.shift};
								if (full_addr == `EEWP_PTR_ADDR) begin
									next_st.ptr_pend = 1'b1;
									next_st.ptr_new  = st.shift;
								end
							end
							next_st.sda_oe = 1'b1;
							next_st.phase  = EEWP_ACK_DATA;
						end else begin
							// Latch path full: refuse the byte with no ack
							next_st.phase = EEWP_IDLE;
						end
					end
				end
				EEWP_ACK_DEV: begin
					if (fall) begin
						// Read modes are not served here: back to idle
						next_st.sda_oe  = 1'b0;
						next_st.bit_cnt = '0;
						next_st.phase   = st.rd_dir ? EEWP_IDLE : EEWP_ADDR;
					end
				end
				EEWP_ACK_ADDR: begin
					if (fall) begin
						next_st.sda_oe  = 1'b0;
						next_st.bit_cnt = '0;
						next_st.phase   = EEWP_DATA;
					end
				end
				EEWP_ACK_DATA: begin
					if (fall) begin
						next_st.sda_oe  = 1'b0;
						next_st.bit_cnt = '0;
						next_st.addr    = next_addr(st.addr, st.page_mode);
						next_st.phase   = EEWP_DATA;
					end
				end
				default: begin
					next_st.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st       <= '0;
			st.phase <= EEWP_IDLE;
			st.ptr   <= `EEWP_PTR_RESET;
			st.scl_sync <= 3'h7;
			st.sda_sync <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	// Latched bytes queue toward the array; a full queue refuses bytes
	eewp_fifo #(
		.WIDTH (18),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_valid (st.push_v),
		.i_data  (st.push_word),
		.o_ready (fifo_ready),
		.o_valid (o_wr_valid),
		.o_data  (fifo_word),
		.i_ready (i_wr_ready)
	);

	// Output mapping
	assign o_wr_addr                  = fifo_word[17:8];
	assign o_wr_data                  = fifo_word[7:0];
	assign o_sda                      = 1'b0;
	assign o_sda_oe                   = st.sda_oe;
	assign o_prog_start               = st.prog_start;
	assign o_busy                     = st.busy;
	assign o_protect_boundary_pointer = st.ptr;

endmodule

`default_nettype wire

// >>> bench/eewp_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks on the front end
module eewp_top_checker #(
	parameter int TW_CYCLES = 200
) (
	// Clock, reset, inputs
	input wire logic       i_clk,
	input wire logic       i_srst,
	input wire logic       i_scl,
	input wire logic       i_wr_ready,
	// Design outputs
	input wire logic       o_sda,
	input wire logic       o_sda_oe,
	input wire logic       o_wr_valid,
	input wire logic [9:0] o_wr_addr,
	input wire logic [7:0] o_wr_data,
	input wire logic       o_prog_start,
	input wire logic       o_busy,
	input wire logic [7:0] o_protect_boundary_pointer
);
	logic [31:0] blen; // Busy cycles so far, held at the fall
	// Counter instead of a long repetition
	always_ff @(posedge i_clk) begin
		if (i_srst || !o_busy) begin
			blen <= '0;
		end else begin
			blen <= blen + 32'h1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	pulse_once_a: assert property (o_prog_start |=> !o_prog_start)
		else $error("start pulse too long");
	busy_follows_a: assert property (o_prog_start |=> o_busy)
		else $error("no busy after start");
	quiet_busy_a: assert property (o_busy && $past(o_busy) |-> !o_sda_oe)
		else $error("ack while busy");
	cycle_len_a: assert property ($fell(o_busy) |-> blen == TW_CYCLES || blen == 2 * TW_CYCLES)
		else $error("program time off");
	ack_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("ack moved while clock high");
	ack_span_a: assert property ($rose(i_scl) && o_sda_oe |-> o_sda_oe [*8])
		else $error("ack dropped early");
	open_drain_a: assert property (o_sda_oe |-> !o_sda)
		else $error("data pin driven high");
	head_hold_a: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable({o_wr_addr, o_wr_data}))
		else $error("latch head moved");
	ptr_update_a: assert property ($changed(o_protect_boundary_pointer) |-> o_prog_start || o_busy)
		else $error("pointer moved outside program");
	cover property (o_prog_start);
	cover property ($fell(o_busy) && blen == 2 * TW_CYCLES);
	cover property (o_wr_valid && !i_wr_ready);
endmodule
`default_nettype wire

// >>> bench/eewp_master.sv
`timescale 1ns/1ps
`default_nettype none
// Two-wire master; its data drive high means released
module eewp_master (
	// Pacing clock
	input  wire logic i_clk,
	// Resolved data wire
	input  wire logic i_sda,
	// Link drive
	output logic      o_scl,
	output logic      o_sda
);
	// Idle bus, clock stands still high
	initial begin
		o_scl = 1'h1;
		o_sda = 1'h1;
	end
	// Quarter of the 160 ns link period
	task automatic q;
		repeat (10) @(posedge i_clk);
	endtask
	// Data falls while clock high
	task automatic start;
		o_sda <= 1'h0;
		q;
		o_scl <= 1'h0;
		q;
	endtask
	// Data rises while clock high
	task automatic stop;
		o_sda <= 1'h0;
		q;
		o_scl <= 1'h1;
		q;
		o_sda <= 1'h1;
		q;
		q;
	endtask
	// Data moves only with clock low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		o_sda <= b;
		q;
		o_scl <= 1'h1;
		q;
		r = i_sda;
		q;
		o_scl <= 1'h0;
		q;
	endtask
	// Byte MSB first, then a released ninth bit
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'h1, r);
		ack = !r;
	endtask
endmodule
`default_nettype wire

// >>> bench/eewp_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Master model on the link, bench on the latch port
module eewp_top_bench;
	localparam int TW = 200;  // Shortened program cycle
	logic        i_clk = 1'h0;
	logic        i_srst = 1'h1;
	logic        cs = 1'h0;    // Chip-select pin
	logic        mode = 1'h0;  // Low page, high multibyte
	logic        wi = 1'h0;    // Write inhibit, read only by the write-control unit
	logic        pe = 1'h0;    // Protect enable
	logic        rdy = 1'h1;   // Latch ready
	logic        scl, m_sda, oe, wv, ps, busy, oe2, wv2;
	logic [9:0]  wa, wa2;
	logic [7:0]  wd, ptr, k, wd2;
	logic [17:0] w2 = '0;      // Last word latched by the write-control unit
	logic [17:0] got [$];      // Words taken at the latch port
	int          err_count = 0;
	int          n_compared = 0;
	int          blen = 0;
	wire logic   sda = m_sda & ~oe & ~oe2; // Pull-up wire
	initial forever #2 i_clk = ~i_clk;
	// Busy length since the last start pulse
	always @(posedge i_clk) blen <= ps ? 0 : (busy ? blen + 1 : blen);
	always @(posedge i_clk) if (wv && rdy) got.push_back({wa, wd});
	eewp_top #(.TW_CYCLES(TW)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_scl(scl),
		.i_sda(sda), .o_sda(), .o_sda_oe(oe), .i_chip_select_pin(cs), .i_mode_pin(mode),
		.i_write_inhibit_pin(wi), .i_protect_enable_pin(pe), .o_wr_valid(wv),
		.o_wr_addr(wa), .o_wr_data(wd), .i_wr_ready(rdy), .o_prog_start(ps),
		.o_busy(busy), .o_protect_boundary_pointer(ptr));
	// Second unit on the same bus: write-control variant, its own type code
	eewp_top #(.TYPE_ID(4'h6), .HW_WRITE_CTRL(1'b1), .TW_CYCLES(TW)) dut_w (.i_clk(i_clk),
		.i_srst(i_srst), .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(oe2),
		.i_chip_select_pin(cs), .i_mode_pin(mode), .i_write_inhibit_pin(wi),
		.i_protect_enable_pin(pe), .o_wr_valid(wv2), .o_wr_addr(wa2), .o_wr_data(wd2),
		.i_wr_ready(1'h1), .o_prog_start(), .o_busy(), .o_protect_boundary_pointer());
	always @(posedge i_clk) if (wv2) w2 <= {wa2, wd2};
	eewp_master m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
	task automatic chk(input string s, input logic [17:0] e, input logic [17:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// Oldest latched word, unknown when none came
	task automatic pop(input logic [17:0] e);
		if (got.size() == 0) chk("latch word", e, 'x);
		else chk("latch word", e, got.pop_front());
	endtask
	// One write transfer; k counts acknowledged bytes
	task automatic xfer(input logic [7:0] sel, a, d, input int n);
		logic ok;
		m.start;
		m.send(sel, ok);
		k = {7'h0, ok};
		if (ok) m.send(a, ok);
		k += {7'h0, ok};
		for (int i = 0; i < n && ok; i++) begin
			m.send(d + 8'(i), ok);
			k += {7'h0, ok};
		end
		m.stop;
	endtask
	task automatic poll(input logic [7:0] sel, input logic e);
		logic ok;
		m.start;
		m.send(sel, ok);
		m.stop;
		chk("poll ack", e, ok);
	endtask
	// Bounded wait for the end of programming
	task automatic idle;
		for (int i = 0; i < 3 * TW && busy !== 1'h0; i++) @(posedge i_clk);
		chk("busy end", 0, busy);
		repeat (8) @(posedge i_clk);
	endtask
	task automatic final_report;
		if (err_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		i_srst <= 1'h0;
		repeat (8) @(posedge i_clk);
		chk("busy", 0, busy);
		chk("pointer", 18'hff, ptr);
		xfer(8'ha0, 8'h00, 8'h00, 1);
		chk("type", 0, k);
		xfer(8'h58, 8'h00, 8'h00, 1);
		chk("chip select", 0, k);
		cs <= 1'h1;
		xfer(8'h5c, 8'h2e, 8'ha1, 3);
		chk("page acks", 18'h5, k);
		poll(8'h5c, 1'h0);
		idle;
		poll(8'h5c, 1'h1);
		pop({2'h2, 8'h2e, 8'ha1});
		pop({2'h2, 8'h2f, 8'ha2});
		pop({2'h2, 8'h20, 8'ha3});
		mode <= 1'h1;
		xfer(8'h5c, 8'h2e, 8'hb1, 3);
		chk("multi acks", 18'h5, k);
		idle;
		chk("two rows", 1, blen > 300);
		pop({2'h2, 8'h2e, 8'hb1});
		pop({2'h2, 8'h2f, 8'hb2});
		pop({2'h2, 8'h30, 8'hb3});
		xfer(8'h5c, 8'h40, 8'hc1, 1);
		idle;
		chk("one row", 1, blen < 300);
		pop({2'h2, 8'h40, 8'hc1});
		mode <= 1'h0;
		xfer(8'h5e, 8'hff, 8'hc0, 1);
		idle;
		chk("pointer", 18'hc0, ptr);
		pop({2'h3, 8'hff, 8'hc0});
		pe <= 1'h1;
		xfer(8'h5e, 8'hc4, 8'h77, 1);
		chk("protected acks", 18'h3, k);
		idle;
		chk("protected kept", 0, 18'(got.size()));
		xfer(8'h5e, 8'hbf, 8'h78, 1);
		idle;
		pop({2'h3, 8'hbf, 8'h78});
		xfer(8'h5c, 8'hf0, 8'h79, 1);
		idle;
		pop({2'h2, 8'hf0, 8'h79});
		rdy <= 1'h0;
		xfer(8'h58, 8'h10, 8'hd1, 5);
		chk("full refusal", 18'h6, k);
		rdy <= 1'h1;
		idle;
		chk("drained", 18'h4, 18'(got.size()));
		pop({2'h0, 8'h10, 8'hd1});
		got.delete();
		xfer(8'h5d, 8'h00, 8'h00, 0);
		chk("read select", 18'h1, k);
		chk("no data", 0, 18'(got.size()));
		// Inhibited write is acknowledged and programs nothing
		wi <= 1'h1;
		xfer(8'h6c, 8'h11, 8'he1, 1);
		chk("inhibit acks", 18'h3, k);
		repeat (300) @(posedge i_clk);
		chk("inhibit kept", 0, w2);
		wi <= 1'h0;
		xfer(8'h6c, 8'h11, 8'he2, 1);
		repeat (300) @(posedge i_clk);
		chk("inhibit off", {2'h2, 8'h11, 8'he2}, w2);
		final_report;
	end
	// Run should take about a fifth of this
	initial begin
		repeat (100000) @(posedge i_clk);
		err_count++;
		final_report;
	end
endmodule
bind eewp_top eewp_top_checker #(.TW_CYCLES(TW_CYCLES)) u_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_scl(i_scl), .i_wr_ready(i_wr_ready),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
	.o_wr_data(o_wr_data), .o_prog_start(o_prog_start), .o_busy(o_busy),
	.o_protect_boundary_pointer(o_protect_boundary_pointer));
`default_nettype wire
